// ### shared/csdae_pkg.sv
package csdae_pkg;

    // opcode fields of the 16-bit instruction word
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 9;
    localparam int ACC_BIT = 8;
    localparam logic [6:0] OPC_CMP_LESS = 7'h30;
    localparam logic [6:0] OPC_CMP_EQUAL = 7'h31;
    localparam logic [6:0] OPC_CMP_GREATER = 7'h32;
    localparam logic [15:0] OPC_DECIMAL_ADJUST = 16'h0007;

    // access bank layout when the access bit is clear
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

    // decimal adjust constants
    localparam logic [3:0] DAW_LIMIT = 4'h9;
    localparam logic [4:0] DAW_STEP = 5'h06;

    // reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [11:0] ADDR_RESET = 12'h000;

    typedef enum logic [1:0] {
        Q1 = 2'b00,
        Q2 = 2'b01,
        Q3 = 2'b10,
        Q4 = 2'b11
    } csdae_quarter_t;

    typedef enum logic [1:0] {
        CYC_EXEC = 2'b00,
        CYC_NOP1 = 2'b01,
        CYC_NOP2 = 2'b10
    } csdae_cycle_t;

    typedef struct packed {
        logic isEq;
        logic isGt;
        logic isLt;
        logic isDaw;
        logic access;
        logic [7:0] addr;
    } csdae_dec_t;

    typedef struct packed {
        logic read;
        logic [11:0] addr;
    } csdae_memreq_t;

    typedef struct packed {
        logic workWr;
        logic [7:0] workVal;
        logic carryWr;
        logic carryVal;
    } csdae_wres_t;

endpackage

// ### design/csdae_nibble_adj.sv
`timescale 1ns/10ps
module csdae_nibble_adj (
    // nibble and correction request
    input wire logic [3:0] nib,
    input wire logic forceAdj,
    input wire logic carryIn,
    // corrected nibble
    output logic [3:0] sum,
    output logic carryOut
);
    wire needAdj;
    wire [4:0] total;

    assign needAdj = (nib > csdae_pkg::DAW_LIMIT) || forceAdj;
    assign total = {1'b0, nib} + (needAdj ? csdae_pkg::DAW_STEP : 5'h00) + {4'h0, carryIn};
    assign sum = total[3:0];
    assign carryOut = total[4];
endmodule

// ### design/csdae_exec.sv
// Overview of operation
// [RL1] decode 0110010a as compare greater skip
// [RL2] greater skip: unsigned, register strictly larger
// [RL3] decode 0110000a as compare less skip
// [RL4] less skip: unsigned, register strictly smaller
// [RL5] compares subtract, no flags, no writes
// [RL6] access bit 0 access bank, else bank select
// [RL7] skip discards fetched word, one no-op cycle
// [RL8] one word; one cycle, two if skipping
// [RL9] two-word skipped instruction: two no-op cycles
// [RL10] equal skip: skip next when equal only
// [RL11] decode 0110001a as compare equal skip
// [RL12] low nibble plus 6 if over 9 or digit carry
// [RL13] high nibble plus 6 if over 9 or carry
// [RL14] decimal adjust on working register, one cycle
// [RL15] decimal adjust sets carry on overflow only; code also keeps carry set if it was already set
// [RL16] decode, read, compare, no write quarters
`timescale 1ns/10ps
module csdae_exec (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // instruction stream
    input wire logic [15:0] instrWord,
    input wire logic nextTwoWord,
    // data memory
    output csdae_pkg::csdae_memreq_t memReq,
    input wire logic [7:0] memData,
    // core state
    input wire logic [7:0] workReg,
    input wire logic carryFlag,
    input wire logic digitCarryFlag,
    input wire logic [3:0] bankSelect,
    // results
    output csdae_pkg::csdae_wres_t wres,
    // sequencing
    output csdae_pkg::csdae_quarter_t quarter,
    output logic discardFetch,
    output logic nopCycle
);
    csdae_pkg::csdae_quarter_t quarter_q, quarter_d;
    csdae_pkg::csdae_cycle_t cyc_q, cyc_d;
    csdae_pkg::csdae_dec_t dec_q, dec_d;
    csdae_pkg::csdae_memreq_t memReq_q, memReq_d;
    csdae_pkg::csdae_wres_t wres_q, wres_d;
    logic [7:0] rdData_q;
    logic [7:0] dawSrc_q;
    logic dawCarry_q;
    logic dawDigit_q;
    logic discard_q;
    logic twoWord_q;
    logic nop_q;

    wire execCyc;
    wire atQ1;
    wire atQ2;
    wire atQ3;
    wire atQ4;
    wire isCmp;
    wire [8:0] diff;
    wire cmpEq;
    wire cmpLt;
    wire cmpGt;
    wire skipNow;
    wire [3:0] bankSel;
    wire [3:0] lowAdj;
    wire [3:0] highAdj;
    wire lowCarry;
    wire highCarry;

    assign execCyc = (cyc_q == csdae_pkg::CYC_EXEC);
    assign atQ1 = (quarter_q == csdae_pkg::Q1);
    assign atQ2 = (quarter_q == csdae_pkg::Q2);
    assign atQ3 = (quarter_q == csdae_pkg::Q3);
    assign atQ4 = (quarter_q == csdae_pkg::Q4);
    assign isCmp = dec_q.isEq || dec_q.isGt || dec_q.isLt;

    // [RL1] [RL3] [RL11] opcode decode
    assign dec_d.isGt = (instrWord[csdae_pkg::OPC_MSB:csdae_pkg::OPC_LSB] == csdae_pkg::OPC_CMP_GREATER);
    assign dec_d.isLt = (instrWord[csdae_pkg::OPC_MSB:csdae_pkg::OPC_LSB] == csdae_pkg::OPC_CMP_LESS);
    assign dec_d.isEq = (instrWord[csdae_pkg::OPC_MSB:csdae_pkg::OPC_LSB] == csdae_pkg::OPC_CMP_EQUAL);
    assign dec_d.isDaw = (instrWord == csdae_pkg::OPC_DECIMAL_ADJUST);
    assign dec_d.access = instrWord[csdae_pkg::ACC_BIT];
    assign dec_d.addr = instrWord[7:0];

    // [RL6] bank selection
    assign bankSel = dec_d.access ? bankSelect :
                     (dec_d.addr < csdae_pkg::ACCESS_SPLIT) ? csdae_pkg::ACCESS_LOW_BANK :
                     csdae_pkg::ACCESS_HIGH_BANK;

    // [RL16] read request in the second quarter
    assign memReq_d.read = execCyc && atQ1 && (dec_d.isEq || dec_d.isGt || dec_d.isLt);
    assign memReq_d.addr = memReq_d.read ? {bankSel, instrWord[7:0]} : csdae_pkg::ADDR_RESET;

    // [RL5] register minus working register
    assign diff = {1'b0, rdData_q} - {1'b0, workReg};
    assign cmpEq = (diff == 9'h000);
    assign cmpLt = diff[8];
    assign cmpGt = !cmpLt && !cmpEq;

    // [RL2] [RL4] [RL10] skip decision
    assign skipNow = execCyc && atQ3 &&
                     ((dec_q.isGt && cmpGt) || (dec_q.isLt && cmpLt) || (dec_q.isEq && cmpEq));

    // [RL12] [RL13] nibble corrections
    csdae_nibble_adj u_low (
        .nib(dawSrc_q[3:0]),
        .forceAdj(dawDigit_q),
        .carryIn(1'b0),
        .sum(lowAdj),
        .carryOut(lowCarry)
    );

    csdae_nibble_adj u_high (
        .nib(dawSrc_q[7:4]),
        .forceAdj(dawCarry_q),
        .carryIn(lowCarry),
        .sum(highAdj),
        .carryOut(highCarry)
    );

    // [RL14] [RL15] write working register and carry in Q4
    assign wres_d.workWr = execCyc && atQ3 && dec_q.isDaw;
    assign wres_d.workVal = wres_d.workWr ? {highAdj, lowAdj} : csdae_pkg::BYTE_RESET;
    assign wres_d.carryWr = wres_d.workWr;
    assign wres_d.carryVal = wres_d.workWr && (highCarry || dawCarry_q);

    assign quarter_d = csdae_pkg::csdae_quarter_t'(quarter_q + 2'b01);

    // [RL7] [RL8] [RL9] no-op cycle sequencing
    always_comb begin
        cyc_d = cyc_q;
        if (atQ4) begin
            case (cyc_q)
                csdae_pkg::CYC_EXEC: begin
                    if (discard_q) begin
                        cyc_d = csdae_pkg::CYC_NOP1;
                    end
                end
                csdae_pkg::CYC_NOP1: begin
                    cyc_d = twoWord_q ? csdae_pkg::CYC_NOP2 : csdae_pkg::CYC_EXEC;
                end
                csdae_pkg::CYC_NOP2: begin
                    cyc_d = csdae_pkg::CYC_EXEC;
                end
                default: begin
                    cyc_d = csdae_pkg::CYC_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            quarter_q <= csdae_pkg::Q1;
            cyc_q <= csdae_pkg::CYC_EXEC;
            nop_q <= 1'b0;
        end else begin
            quarter_q <= quarter_d;
            cyc_q <= cyc_d;
            nop_q <= (cyc_d != csdae_pkg::CYC_EXEC);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dec_q <= '0;
        end else if (execCyc && atQ1) begin
            dec_q <= dec_d;
        end else if (atQ4 || !execCyc) begin
            dec_q <= '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            memReq_q <= '0;
        end else begin
            memReq_q <= memReq_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdData_q <= csdae_pkg::BYTE_RESET;
            dawSrc_q <= csdae_pkg::BYTE_RESET;
            dawCarry_q <= 1'b0;
            dawDigit_q <= 1'b0;
        end else if (execCyc && atQ2) begin
            rdData_q <= memData;
            dawSrc_q <= workReg;
            dawCarry_q <= carryFlag;
            dawDigit_q <= digitCarryFlag;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            discard_q <= 1'b0;
            twoWord_q <= 1'b0;
            wres_q <= '0;
        end else begin
            discard_q <= skipNow;
            wres_q <= wres_d;
            if (skipNow) begin
                twoWord_q <= nextTwoWord;
            end
        end
    end

    assign memReq = memReq_q;
    assign wres = wres_q;
    assign quarter = quarter_q;
    assign discardFetch = discard_q;
    assign nopCycle = nop_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_nop_one;
        nopCycle [*4];
    endsequence

    sequence s_nop_two;
        s_nop_one ##1 nopCycle [*4];
    endsequence

    property p_read_q2;
        memReq.read |-> (quarter_q == csdae_pkg::Q2) && $past(instrWord[15:12]) == 4'h6;
    endproperty
    a_read_q2: assert property (p_read_q2) else $error("register read outside second quarter"); // [RL16]

    property p_decode_gt;
        (execCyc && atQ1 && instrWord[15:9] == 7'h32) |=> dec_q.isGt && !dec_q.isLt && !dec_q.isEq;
    endproperty
    a_decode_gt: assert property (p_decode_gt) else $error("greater compare not decoded"); // [RL1]

    property p_decode_lt;
        (execCyc && atQ1 && instrWord[15:9] == 7'h30) |=> dec_q.isLt && !dec_q.isGt && !dec_q.isEq;
    endproperty
    a_decode_lt: assert property (p_decode_lt) else $error("less compare not decoded"); // [RL3]

    property p_decode_eq;
        (execCyc && atQ1 && instrWord[15:9] == 7'h31) |=> (memReq.read && dec_q.isEq) ##2 dec_q.isEq;
    endproperty
    a_decode_eq: assert property (p_decode_eq) else $error("equal compare not decoded"); // [RL11]

    property p_gt_skip;
        (execCyc && atQ3 && dec_q.isGt) |=> discardFetch == (rdData_q > $past(workReg));
    endproperty
    a_gt_skip: assert property (p_gt_skip) else $error("greater skip decision wrong"); // [RL2]

    property p_lt_skip;
        (execCyc && atQ3 && dec_q.isLt) |=> discardFetch == (rdData_q < $past(workReg));
    endproperty
    a_lt_skip: assert property (p_lt_skip) else $error("less skip decision wrong"); // [RL4]

    property p_eq_skip;
        (execCyc && atQ3 && dec_q.isEq) |=> discardFetch == (rdData_q == $past(workReg));
    endproperty
    a_eq_skip: assert property (p_eq_skip) else $error("equal skip decision wrong"); // [RL10]

    property p_cmp_no_write;
        isCmp |-> (!wres.workWr && !wres.carryWr) ##1 (!wres.workWr && !wres.carryWr);
    endproperty
    a_cmp_no_write: assert property (p_cmp_no_write) else $error("compare wrote a result"); // [RL5]

    property p_bank;
        memReq.read |-> memReq.addr[11:8] == (dec_q.access ? $past(bankSelect) :
                        (dec_q.addr[7] ? 4'hf : 4'h0));
    endproperty
    a_bank: assert property (p_bank) else $error("wrong bank addressed"); // [RL6]

    property p_skip_one;
        (discardFetch && !twoWord_q) |=> s_nop_one ##1 !nopCycle;
    endproperty
    a_skip_one: assert property (p_skip_one) else $error("single no-op cycle missing"); // [RL7]

    property p_no_skip;
        (execCyc && atQ4 && !discardFetch) |=> !nopCycle [*4];
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("no-op cycle without skip"); // [RL8]

    property p_skip_two;
        (discardFetch && twoWord_q) |=> s_nop_two ##1 !nopCycle;
    endproperty
    a_skip_two: assert property (p_skip_two) else $error("two no-op cycles missing"); // [RL9]

    property p_daw_low;
        wres.workWr && !dawDigit_q |-> wres.workVal[3:0] ==
            ((dawSrc_q[3:0] > 4'h9) ? 4'(dawSrc_q[3:0] + 4'h6) : dawSrc_q[3:0]);
    endproperty
    a_daw_low: assert property (p_daw_low) else $error("low nibble adjust wrong"); // [RL12]

    property p_daw_high;
        wres.workWr && dawSrc_q[3:0] < 4'ha && !dawDigit_q |-> wres.workVal[7:4] ==
            ((dawSrc_q[7:4] > 4'h9 || dawCarry_q) ? 4'(dawSrc_q[7:4] + 4'h6) : dawSrc_q[7:4]);
    endproperty
    a_daw_high: assert property (p_daw_high) else $error("high nibble adjust wrong"); // [RL13]

    property p_daw_timing;
        (execCyc && atQ1 && instrWord == 16'h0007) |=> ##2 wres.workWr ##1 !wres.workWr && !nopCycle;
    endproperty
    a_daw_timing: assert property (p_daw_timing) else $error("decimal adjust not single cycle"); // [RL14]

    property p_daw_carry;
        wres.carryWr |-> wres.carryVal == (dawCarry_q || (dawSrc_q[7:4] > 4'h9));
    endproperty
    a_daw_carry: assert property (p_daw_carry) else $error("decimal adjust carry wrong"); // [RL15]

endmodule

// ### tb/csdae_mem_model.sv
`timescale 1ns/10ps
module csdae_mem_model (
    // clock
    input wire logic clk_sys,
    // read request and data
    input wire csdae_pkg::csdae_memreq_t memReq,
    output logic [7:0] memData
);
    logic [7:0] mem [0:4095];
    logic [7:0] lastQ;
    // data only while read is high, inverted last value otherwise
    assign memData = memReq.read ? mem[memReq.addr] : ~lastQ;
    initial begin
        lastQ = 8'h00;
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
    end
    always @(posedge clk_sys) begin
        if (memReq.read) begin
            lastQ <= mem[memReq.addr];
        end
    end
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic clk_sys, rst_n, nextTwoWord, carryFlag, digitCarryFlag, discardFetch, nopCycle;
    logic [15:0] instrWord;
    logic [7:0] memData, workReg;
    logic [3:0] bankSelect;
    csdae_pkg::csdae_memreq_t memReq;
    csdae_pkg::csdae_wres_t wres;
    csdae_pkg::csdae_quarter_t quarter;
    int nFail, cmpCount, cycles;
    csdae_exec u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .instrWord(instrWord), .nextTwoWord(nextTwoWord),
        .memReq(memReq), .memData(memData), .workReg(workReg), .carryFlag(carryFlag),
        .digitCarryFlag(digitCarryFlag), .bankSelect(bankSelect), .wres(wres), .quarter(quarter),
        .discardFetch(discardFetch), .nopCycle(nopCycle));
    csdae_mem_model u_mem (.clk_sys(clk_sys), .memReq(memReq), .memData(memData));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            nFail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            nFail++;
            report_and_stop();
        end
    end
    // adjusted value with carry on top
    function automatic logic [8:0] dawExp(input logic [7:0] w, input logic c, input logic dc);
        logic [8:0] t;
        t = {1'b0, w};
        if (w[3:0] > 4'h9 || dc) t = t + 9'h006;
        if (w[7:4] > 4'h9 || c) t = t + 9'h060;
        return {c | t[8], t[7:0]};
    endfunction
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask
    // kind 0 less, 1 equal, 2 greater, 3 adjust, 4 undefined
    task automatic exec(input int kind, input logic acc, input logic [7:0] f, input logic [7:0] m,
        input logic [7:0] w, input logic [3:0] bank, input logic c, input logic dc, input logic two);
        logic [11:0] a;
        logic sk;
        logic [8:0] d;
        int n;
        int e;
        logic [31:0] ew;
        a = acc ? {bank, f} : {(f < 8'h80) ? 4'h0 : 4'hf, f};
        sk = (kind == 0 && m < w) || (kind == 1 && m == w) || (kind == 2 && m > w);
        d = dawExp(w, c, dc);
        ew = (kind == 3) ? {21'h000000, 1'b1, d[7:0], 1'b1, d[8]} : 32'h00000000;
        e = sk ? (two ? 8 : 4) : 0;
        n = 0;
        u_mem.mem[a] = m;
        instrWord = (kind == 3) ? 16'h0007 : {4'h6, (kind == 4) ? 3'h3 : 3'(kind), acc, f};
        workReg = w;
        carryFlag = c;
        digitCarryFlag = dc;
        bankSelect = bank;
        nextTwoWord = two;
        tick();
        check(32'({memReq}), (kind < 3) ? {19'h00000, 1'b1, a} : 32'h00000000);
        check(32'(quarter), 32'h00000001);
        tick();
        tick();
        check(32'(discardFetch), 32'(sk));
        check(32'({wres}), ew);
        repeat (e) begin
            tick();
            n += nopCycle;
        end
        tick();
        check(32'(n), 32'(e));
        check(32'({nopCycle, quarter}), 32'h00000000);
    endtask
    initial begin
        rst_n = 1'b0;
        instrWord = 16'h0000;
        nextTwoWord = 1'b0;
        workReg = 8'h00;
        carryFlag = 1'b0;
        digitCarryFlag = 1'b0;
        bankSelect = 4'h0;
        nFail = 0;
        cmpCount = 0;
        cycles = 0;
        void'($urandom(55));
        repeat (8) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        exec(3, 0, 8'h00, 8'h00, 8'ha5, 4'h0, 0, 0, 0);
        exec(3, 0, 8'h00, 8'h00, 8'hce, 4'h0, 0, 0, 0);
        exec(3, 0, 8'h00, 8'h00, 8'h99, 4'h0, 1, 1, 0);
        exec(3, 0, 8'h00, 8'h00, 8'h12, 4'h0, 0, 0, 0);
        $display("test adjust done");
        for (int k = 0; k < 3; k++) begin
            for (int r = 0; r < 3; r++) begin
                exec(k, r == 2, (r == 1) ? 8'h80 : 8'h7f, 8'h40 + 8'(r), 8'h41, 4'h5, 1, 1, r == 2);
            end
        end
        exec(0, 1, 8'h00, 8'h00, 8'hff, 4'ha, 0, 0, 1);
        exec(2, 1, 8'hff, 8'hff, 8'h00, 4'h3, 0, 0, 0);
        exec(4, 1, 8'h10, 8'h10, 8'h10, 4'h1, 1, 0, 0);
        $display("test compare done");
        repeat (150) begin
            exec($urandom_range(4, 0), 1'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
                4'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
        end
        $display("test random done");
        instrWord = 16'h6400;
        tick();
        rst_n = 1'b0;
        tick();
        check(32'({memReq, wres, discardFetch, nopCycle, quarter}), 32'h00000000);
        rst_n = 1'b1;
        exec(1, 0, 8'h20, 8'h33, 8'h33, 4'h0, 0, 0, 0);
        $display("test reset done");
        report_and_stop();
    end
endmodule
